// [lcd_pkg.sv]
package lcd_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int EXEC_TIME_NS = 80;
  localparam int EXEC_CYCLES =
    (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // storage sizes
  localparam int TEXT_WORDS = 32;
  localparam int GLYPH_WORDS = 64;
  localparam int BITMAP_WORDS = 1024;

  // ==========================================================
  // instruction fields
  localparam int BUSY_BIT = 7;
  localparam int FS_DL_BIT = 4;
  localparam int FS_RE_BIT = 2;
  localparam int FS_G_BIT = 1;

  // ==========================================================
  // reset values
  localparam logic [6:0] AC_RESET = 7'h00;
  localparam logic DL_RESET = 1'b1;
  localparam logic RE_RESET = 1'b0;
  localparam logic G_RESET = 1'b0;
  localparam logic SR_RESET = 1'b0;
  localparam logic DIR_RESET = 1'b1;
  localparam logic [1:0] INV_SEL_RESET = 2'h0;

  typedef enum logic [2:0] {
    MEM_TEXT = 3'b001,
    MEM_GLYPH = 3'b010,
    MEM_BITMAP = 3'b100
  } mem_sel_t;

  // row 0..3 and column to text word index
  function automatic logic [4:0] text_index(input logic [1:0] row,
                                            input logic [2:0] col);
    text_index = {row[0], row[1], col};
  endfunction : text_index

endpackage : lcd_pkg

// [lcd_link_if.sv]
`timescale 1ns/1ps
interface lcd_link_if;
  logic strobe;
  logic command_or_data;
  logic read_not_write;
  logic [7:0] db_to_dev;
  logic [7:0] db_to_host;
  logic rd_valid;

  modport device (
    input strobe,
    input command_or_data,
    input read_not_write,
    input db_to_dev,
    output db_to_host,
    output rd_valid
  );

  modport host (
    output strobe,
    output command_or_data,
    output read_not_write,
    output db_to_dev,
    input db_to_host,
    input rd_valid
  );
endinterface : lcd_link_if

// [lcd_device.sv]
`timescale 1ns/1ps
module lcd_device #(
  parameter int EXEC_CYCLES = lcd_pkg::EXEC_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  lcd_link_if.device link,
  input lcd_pkg::mem_sel_t scan_sel,
  input wire logic [9:0] scan_addr,
  output logic [15:0] scan_word,
  output logic [6:0] address_counter,
  output logic busy_flag,
  output logic bitmap_on,
  output logic standby,
  output logic scroll_select,
  output logic bus_width_select,
  output logic extended_set_select,
  output logic invert_row_high,
  output logic invert_row_low,
  output logic [3:0] row_invert,
  output logic [5:0] scroll_offset
);
  localparam int CW = $clog2(EXEC_CYCLES + 1);

  logic [6:0] ac_q, ac_d;
  logic dir_q, dir_d, dl_q, dl_d, re_q, re_d, g_q, g_d, sr_q, sr_d;
  logic stby_q, stby_d, gph_q, gph_d, nib_q, nib_d;
  logic wsel_q, wsel_d, rsel_q, rsel_d, dummy_q, dummy_d;
  logic fetch_q, fetch_d, rdv_q, rdv_d;
  logic [1:0] isel_q, isel_d;
  logic [3:0] rinv_q, rinv_d;
  logic [5:0] scroll_q, scroll_d, vert_q, vert_d;
  logic [7:0] hold_q, hold_d, whi_q, whi_d, rdat_q, rdat_d;
  logic [15:0] rbuf_q, rbuf_d, scan_q, scan_d;
  logic [CW-1:0] cnt_q, cnt_d;
  lcd_pkg::mem_sel_t msel_q, msel_d;

  logic [15:0] text_mem [0:lcd_pkg::TEXT_WORDS-1];
  logic [15:0] glyph_mem [0:lcd_pkg::GLYPH_WORDS-1];
  logic [15:0] bitmap_mem [0:lcd_pkg::BITMAP_WORDS-1];
  logic [15:0] mem_rd;
  logic mem_we;

  logic busy, status_rd, accept, addr_set;
  logic [7:0] byte_in, rd_val;

  function automatic logic [6:0] stepped(input logic [6:0] a,
                                         input logic bmp,
                                         input logic up);
    if (bmp) begin
      stepped = {a[6:4], a[3:0] + 4'h1};
    end else if (up) begin
      stepped = a + 7'h01;
    end else begin
      stepped = a - 7'h01;
    end
  endfunction : stepped

  // ==========================================================
  // storage access
  always_comb begin
    case (msel_q)
      lcd_pkg::MEM_GLYPH: mem_rd = glyph_mem[ac_q[5:0]];
      lcd_pkg::MEM_BITMAP: mem_rd = bitmap_mem[{vert_q, ac_q[3:0]}];
      default: mem_rd = text_mem[ac_q[4:0]];
    endcase
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      case (msel_q)
        lcd_pkg::MEM_GLYPH: glyph_mem[ac_q[5:0]] <= {whi_q, byte_in};
        lcd_pkg::MEM_BITMAP:
          bitmap_mem[{vert_q, ac_q[3:0]}] <= {whi_q, byte_in};
        default: text_mem[ac_q[4:0]] <= {whi_q, byte_in};
      endcase
    end
  end

  // ==========================================================
  // link decode
  // a pending prefetch counts as busy so a read never sees stale data
  assign busy = (cnt_q != '0) || fetch_q;
  assign status_rd = !link.command_or_data && link.read_not_write;
  assign accept = link.strobe && (status_rd || !busy);
  assign byte_in = dl_q ? link.db_to_dev
                        : {hold_q[7:4], link.db_to_dev[7:4]};
  assign rd_val = status_rd ? {busy, ac_q}
                            : (rsel_q ? rbuf_q[7:0] : rbuf_q[15:8]);

  always_comb begin
    ac_d = ac_q;
    dir_d = dir_q;
    dl_d = dl_q;
    re_d = re_q;
    g_d = g_q;
    sr_d = sr_q;
    stby_d = stby_q;
    gph_d = gph_q;
    nib_d = nib_q;
    wsel_d = wsel_q;
    rsel_d = rsel_q;
    dummy_d = dummy_q;
    fetch_d = fetch_q;
    isel_d = isel_q;
    rinv_d = rinv_q;
    scroll_d = scroll_q;
    vert_d = vert_q;
    hold_d = hold_q;
    whi_d = whi_q;
    rdat_d = rdat_q;
    rbuf_d = rbuf_q;
    msel_d = msel_q;
    cnt_d = cnt_q;
    rdv_d = 1'b0;
    mem_we = 1'b0;
    addr_set = 1'b0;
    if (cnt_q != '0) begin
      cnt_d = cnt_q - CW'(1);
    end
    if (fetch_q && cnt_q == '0) begin
      rbuf_d = mem_rd;
      fetch_d = 1'b0;
    end
    if (accept && !dl_q && !nib_q) begin
      // first nibble: a read answers with the high half of the byte
      nib_d = 1'b1;
      rdv_d = link.read_not_write;
      if (link.read_not_write) begin
        hold_d = rd_val;
        rdat_d = {rd_val[7:4], 4'h0};
      end else begin
        hold_d = {link.db_to_dev[7:4], 4'h0};
      end
    end else if (accept) begin
      nib_d = 1'b0;
      rdv_d = link.read_not_write;
      if (link.read_not_write) begin
        rdat_d = dl_q ? rd_val : {hold_q[3:0], 4'h0};
      end
      if (!status_rd) begin
        cnt_d = CW'(EXEC_CYCLES);
        stby_d = 1'b0;
      end
      if (link.command_or_data && !link.read_not_write) begin
        dummy_d = 1'b1;
        rsel_d = 1'b0;
        if (!wsel_q) begin
          whi_d = byte_in;
          wsel_d = 1'b1;
        end else begin
          mem_we = 1'b1;
          wsel_d = 1'b0;
          ac_d = stepped(ac_q, msel_q == lcd_pkg::MEM_BITMAP, dir_q);
        end
      end else if (link.command_or_data) begin
        if (dummy_q) begin
          dummy_d = 1'b0;
          fetch_d = 1'b1;
        end else if (!rsel_q) begin
          rsel_d = 1'b1;
        end else begin
          rsel_d = 1'b0;
          fetch_d = 1'b1;
          ac_d = stepped(ac_q, msel_q == lcd_pkg::MEM_BITMAP, dir_q);
        end
      end else if (!status_rd) begin
        gph_d = 1'b0;
        if (byte_in[7] && re_q) begin
          if (!gph_q) begin
            vert_d = byte_in[5:0];
            gph_d = 1'b1;
          end else begin
            ac_d = {3'h0, byte_in[3:0]};
            msel_d = lcd_pkg::MEM_BITMAP;
            addr_set = 1'b1;
          end
        end else if (byte_in[7]) begin
          ac_d = {1'b0, byte_in[5:0]};
          msel_d = lcd_pkg::MEM_TEXT;
          addr_set = 1'b1;
        end else if (byte_in[6] && re_q) begin
          if (sr_q) begin
            scroll_d = byte_in[5:0];
          end
        end else if (byte_in[6]) begin
          if (!sr_q) begin
            ac_d = {1'b0, byte_in[5:0]};
            msel_d = lcd_pkg::MEM_GLYPH;
            addr_set = 1'b1;
          end
        end else if (byte_in[5]) begin
          dl_d = byte_in[lcd_pkg::FS_DL_BIT];
          re_d = byte_in[lcd_pkg::FS_RE_BIT];
          if (byte_in[lcd_pkg::FS_RE_BIT]) begin
            g_d = byte_in[lcd_pkg::FS_G_BIT];
          end
        end else if (byte_in[4] || byte_in[3]) begin
          // cursor and display control have no effect here
        end else if (byte_in[2]) begin
          if (re_q) begin
            isel_d = byte_in[1:0];
            rinv_d[byte_in[1:0]] = ~rinv_q[byte_in[1:0]];
          end else begin
            dir_d = byte_in[1];
          end
        end else if (byte_in[1]) begin
          if (re_q) begin
            sr_d = byte_in[0];
          end
        end else if (byte_in[0] && re_q) begin
          stby_d = 1'b1;
        end
        // any address-style command re-arms the dummy, as the host assumes
        if (addr_set || byte_in[7] || byte_in[6]) begin
          dummy_d = 1'b1;
          rsel_d = 1'b0;
          wsel_d = 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // display scan port
  always_comb begin
    case (scan_sel)
      lcd_pkg::MEM_GLYPH: scan_d = glyph_mem[scan_addr[5:0]];
      lcd_pkg::MEM_BITMAP: scan_d = bitmap_mem[scan_addr];
      default:
        scan_d = text_mem[lcd_pkg::text_index(scan_addr[4:3],
                                              scan_addr[2:0])];
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ac_q <= lcd_pkg::AC_RESET;
      dir_q <= lcd_pkg::DIR_RESET;
      dl_q <= lcd_pkg::DL_RESET;
      re_q <= lcd_pkg::RE_RESET;
      g_q <= lcd_pkg::G_RESET;
      sr_q <= lcd_pkg::SR_RESET;
      isel_q <= lcd_pkg::INV_SEL_RESET;
      rinv_q <= 4'h0;
      stby_q <= 1'b0;
      gph_q <= 1'b0;
      nib_q <= 1'b0;
      wsel_q <= 1'b0;
      rsel_q <= 1'b0;
      dummy_q <= 1'b1;
      fetch_q <= 1'b0;
      rdv_q <= 1'b0;
      scroll_q <= 6'h00;
      vert_q <= 6'h00;
      hold_q <= 8'h00;
      whi_q <= 8'h00;
      rdat_q <= 8'h00;
      rbuf_q <= 16'h0000;
      scan_q <= 16'h0000;
      msel_q <= lcd_pkg::MEM_TEXT;
      cnt_q <= '0;
    end else begin
      ac_q <= ac_d;
      dir_q <= dir_d;
      dl_q <= dl_d;
      re_q <= re_d;
      g_q <= g_d;
      sr_q <= sr_d;
      isel_q <= isel_d;
      rinv_q <= rinv_d;
      stby_q <= stby_d;
      gph_q <= gph_d;
      nib_q <= nib_d;
      wsel_q <= wsel_d;
      rsel_q <= rsel_d;
      dummy_q <= dummy_d;
      fetch_q <= fetch_d;
      rdv_q <= rdv_d;
      scroll_q <= scroll_d;
      vert_q <= vert_d;
      hold_q <= hold_d;
      whi_q <= whi_d;
      rdat_q <= rdat_d;
      rbuf_q <= rbuf_d;
      scan_q <= scan_d;
      msel_q <= msel_d;
      cnt_q <= cnt_d;
    end
  end

  assign link.db_to_host = rdat_q;
  assign link.rd_valid = rdv_q;
  assign scan_word = scan_q;
  assign address_counter = ac_q;
  assign busy_flag = busy;
  assign bitmap_on = g_q;
  assign standby = stby_q;
  assign scroll_select = sr_q;
  assign bus_width_select = dl_q;
  assign extended_set_select = re_q;
  assign invert_row_high = isel_q[1];
  assign invert_row_low = isel_q[0];
  assign row_invert = rinv_q;
  assign scroll_offset = scroll_q;

endmodule : lcd_device

// [lcd_host.sv]
`timescale 1ns/1ps
module lcd_host (
  input wire logic clk,
  input wire logic nrst,
  lcd_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_is_data,
  input wire logic req_is_read,
  input wire logic [7:0] req_byte,
  output logic resp_valid,
  output logic [7:0] resp_byte
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_STROBE = 4'b0010,
    H_RWAIT = 4'b0100,
    H_NEXT = 4'b1000
  } hstate_t;

  hstate_t st_q, st_d;
  logic poll_q, poll_d, pre_q, pre_d, dum_q, dum_d, nib_q, nib_d;
  logic need_q, need_d, dl_q, dl_d, re_q, re_d, g_q, g_d;
  logic rs_q, rs_d, rw_q, rw_d, rv_q, rv_d;
  logic stb_q, stb_d, lcd_q, lcd_d, lrw_q, lrw_d;
  logic [7:0] byte_q, byte_d, acc_q, acc_d, rb_q, rb_d, ldb_q, ldb_d;
  logic [9:0] cur, nxt;

  // returns {command_or_data, read_not_write, byte} of the step due
  function automatic logic [9:0] op_of(input logic poll,
                                       input logic pre,
                                       input logic dum,
                                       input logic rs,
                                       input logic rw,
                                       input logic [7:0] b,
                                       input logic re);
    if (poll) begin
      op_of = {1'b0, 1'b1, 8'h00};
    end else if (pre) begin
      // width or bitmap change first, set selection later
      op_of = {1'b0, 1'b0, b[7:3], re, re & b[1], b[0]};
    end else if (dum) begin
      op_of = {1'b1, 1'b1, 8'h00};
    end else begin
      op_of = {rs, rw, b};
    end
  endfunction : op_of

  assign cur = op_of(poll_q, pre_q, dum_q, rs_q, rw_q, byte_q, re_q);

  // ==========================================================
  // sequencer
  always_comb begin
    st_d = st_q;
    poll_d = poll_q;
    pre_d = pre_q;
    dum_d = dum_q;
    nib_d = nib_q;
    need_d = need_q;
    dl_d = dl_q;
    re_d = re_q;
    g_d = g_q;
    rs_d = rs_q;
    rw_d = rw_q;
    byte_d = byte_q;
    acc_d = acc_q;
    rb_d = rb_q;
    rv_d = 1'b0;
    case (st_q)
      H_IDLE: begin
        if (req_valid) begin
          rs_d = req_is_data;
          rw_d = req_is_read;
          byte_d = req_byte;
          poll_d = 1'b1;
          pre_d = !req_is_data && !req_is_read
                  && req_byte[7:5] == 3'h1
                  && req_byte[lcd_pkg::FS_RE_BIT] != re_q
                  && (req_byte[lcd_pkg::FS_DL_BIT] != dl_q
                      || (re_q && req_byte[lcd_pkg::FS_G_BIT] != g_q));
          dum_d = req_is_data && req_is_read && need_q;
          st_d = H_STROBE;
        end
      end
      H_STROBE: begin
        st_d = cur[8] ? H_RWAIT : H_NEXT;
      end
      H_RWAIT: begin
        if (link.rd_valid) begin
          if (dl_q) begin
            acc_d = link.db_to_host;
          end else if (!nib_q) begin
            acc_d = {link.db_to_host[7:4], acc_q[3:0]};
          end else begin
            acc_d = {acc_q[7:4], link.db_to_host[7:4]};
          end
          st_d = H_NEXT;
        end
      end
      H_NEXT: begin
        st_d = H_STROBE;
        if (!dl_q && !nib_q) begin
          nib_d = 1'b1;
        end else begin
          nib_d = 1'b0;
          if (poll_q) begin
            poll_d = acc_q[lcd_pkg::BUSY_BIT];
          end else begin
            if (!cur[9] && !cur[8] && cur[7:5] == 3'h1) begin
              dl_d = cur[lcd_pkg::FS_DL_BIT];
              re_d = cur[lcd_pkg::FS_RE_BIT];
              if (cur[lcd_pkg::FS_RE_BIT]) begin
                g_d = cur[lcd_pkg::FS_G_BIT];
              end
            end
            if (!cur[8] && (cur[9] || cur[7] || cur[6])) begin
              need_d = 1'b1;
            end else if (cur[9] && cur[8]) begin
              need_d = 1'b0;
            end
            if (pre_q) begin
              pre_d = 1'b0;
              poll_d = 1'b1;
            end else if (dum_q) begin
              dum_d = 1'b0;
              poll_d = 1'b1;
            end else begin
              rv_d = cur[8];
              rb_d = acc_q;
              st_d = H_IDLE;
            end
          end
        end
      end
      default: st_d = H_IDLE;
    endcase
  end

  // ==========================================================
  // link drive, registered from the next step
  assign nxt = op_of(poll_d, pre_d, dum_d, rs_d, rw_d, byte_d, re_d);

  always_comb begin
    stb_d = (st_d == H_STROBE);
    lcd_d = nxt[9];
    lrw_d = nxt[8];
    if (dl_d) begin
      ldb_d = nxt[7:0];
    end else if (nib_d) begin
      ldb_d = {nxt[3:0], 4'h0};
    end else begin
      ldb_d = {nxt[7:4], 4'h0};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= H_IDLE;
      poll_q <= 1'b0;
      pre_q <= 1'b0;
      dum_q <= 1'b0;
      nib_q <= 1'b0;
      need_q <= 1'b1;
      dl_q <= lcd_pkg::DL_RESET;
      re_q <= lcd_pkg::RE_RESET;
      g_q <= lcd_pkg::G_RESET;
      rs_q <= 1'b0;
      rw_q <= 1'b0;
      rv_q <= 1'b0;
      byte_q <= 8'h00;
      acc_q <= 8'h00;
      rb_q <= 8'h00;
      stb_q <= 1'b0;
      lcd_q <= 1'b0;
      lrw_q <= 1'b0;
      ldb_q <= 8'h00;
    end else begin
      st_q <= st_d;
      poll_q <= poll_d;
      pre_q <= pre_d;
      dum_q <= dum_d;
      nib_q <= nib_d;
      need_q <= need_d;
      dl_q <= dl_d;
      re_q <= re_d;
      g_q <= g_d;
      rs_q <= rs_d;
      rw_q <= rw_d;
      rv_q <= rv_d;
      byte_q <= byte_d;
      acc_q <= acc_d;
      rb_q <= rb_d;
      stb_q <= stb_d;
      lcd_q <= lcd_d;
      lrw_q <= lrw_d;
      ldb_q <= ldb_d;
    end
  end

  assign req_ready = (st_q == H_IDLE);
  assign resp_valid = rv_q;
  assign resp_byte = rb_q;
  assign link.strobe = stb_q;
  assign link.command_or_data = lcd_q;
  assign link.read_not_write = lrw_q;
  assign link.db_to_dev = ldb_q;

endmodule : lcd_host

// [lcd_link_assertions.sv]
`timescale 1ns/1ps
module lcd_link_assertions #(
  parameter int EXEC_CYCLES = lcd_pkg::EXEC_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic strobe,
  input wire logic command_or_data,
  input wire logic read_not_write,
  input wire logic [7:0] db_to_dev,
  input wire logic [7:0] db_to_host,
  input wire logic rd_valid
);
  // ==========================================================
  // cycles since the last write transfer, saturating
  // margin of one cycle: where busy starts is the design's choice
  localparam logic [7:0] BUSY_SPAN = 8'(EXEC_CYCLES - 2);
  logic [7:0] since_wr_q;
  logic [7:0] since_wr_d;
  logic status_rd;

  assign status_rd = strobe && !command_or_data && read_not_write;

  always_comb begin
    since_wr_d = since_wr_q;
    if (strobe && !read_not_write) begin
      since_wr_d = 8'h00;
    end else if (since_wr_q != 8'hFF) begin
      since_wr_d = since_wr_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      since_wr_q <= 8'hFF;
    end else begin
      since_wr_q <= since_wr_d;
    end
  end

  // ==========================================================
  // link properties
  a_status_answer:
    assert property (@(posedge clk) disable iff (!nrst)
      status_rd |=> rd_valid)
    else $error("status read not answered");
  a_data_answer:
    assert property (@(posedge clk) disable iff (!nrst)
      strobe && command_or_data && read_not_write |=> rd_valid)
    else $error("data read not answered");
  a_write_silent:
    assert property (@(posedge clk) disable iff (!nrst)
      strobe && !read_not_write |=> !rd_valid)
    else $error("write produced a read answer");
  a_answer_cause:
    assert property (@(posedge clk) disable iff (!nrst)
      rd_valid |-> $past(strobe && read_not_write))
    else $error("read answer without read transfer");
  a_answer_pulse:
    assert property (@(posedge clk) disable iff (!nrst)
      rd_valid |=> !rd_valid)
    else $error("read answer longer than one cycle");
  a_answer_holds:
    assert property (@(posedge clk) disable iff (!nrst)
      !rd_valid |-> $stable(db_to_host))
    else $error("read data changed without answer");
  a_busy_after_write:
    assert property (@(posedge clk) disable iff (!nrst)
      status_rd && since_wr_q <= BUSY_SPAN |=> db_to_host[7])
    else $error("busy clear too soon after a write");
  a_reset_quiet:
    assert property (@(posedge clk)
      !nrst |=> !strobe && !rd_valid)
    else $error("link active during reset");
endmodule : lcd_link_assertions

// [test_lcd_extended_instruction_decoder.sv]
`timescale 1ns/1ps
module test_lcd_extended_instruction_decoder;
  // ==========================================================
  // signals
  localparam int EXEC = 4;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic req_is_data = 1'b0;
  logic req_is_read = 1'b0;
  logic [7:0] req_byte = 8'h00;
  logic req_ready, resp_valid;
  logic [7:0] resp_byte;
  lcd_pkg::mem_sel_t scan_sel = lcd_pkg::MEM_TEXT;
  logic [9:0] scan_addr = 10'h000;
  logic [15:0] scan_word;
  logic [6:0] address_counter;
  logic busy_flag, bitmap_on, standby, scroll_select;
  logic bus_width_select, extended_set_select;
  logic invert_row_high, invert_row_low;
  logic [3:0] row_invert, m;
  logic [5:0] scroll_offset, rowv;
  logic [10:0] flags;
  logic [7:0] got;
  logic cap_on = 1'b0;
  logic [7:0] capq [$];
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;

  assign rowv = {invert_row_high, invert_row_low, row_invert};
  assign flags = {bitmap_on, standby, scroll_select, bus_width_select,
                  extended_set_select, rowv};

  lcd_link_if link ();

  lcd_device #(.EXEC_CYCLES(EXEC)) lcd_device_i (
    .clk(clk), .nrst(nrst), .link(link), .scan_sel(scan_sel),
    .scan_addr(scan_addr), .scan_word(scan_word),
    .address_counter(address_counter), .busy_flag(busy_flag),
    .bitmap_on(bitmap_on), .standby(standby),
    .scroll_select(scroll_select), .bus_width_select(bus_width_select),
    .extended_set_select(extended_set_select),
    .invert_row_high(invert_row_high), .invert_row_low(invert_row_low),
    .row_invert(row_invert), .scroll_offset(scroll_offset));

  lcd_host lcd_host_i (
    .clk(clk), .nrst(nrst), .link(link), .req_valid(req_valid),
    .req_ready(req_ready), .req_is_data(req_is_data),
    .req_is_read(req_is_read), .req_byte(req_byte),
    .resp_valid(resp_valid), .resp_byte(resp_byte));

  lcd_link_assertions #(.EXEC_CYCLES(EXEC)) lcd_link_assertions_i (
    .clk(clk), .nrst(nrst), .strobe(link.strobe),
    .command_or_data(link.command_or_data),
    .read_not_write(link.read_not_write), .db_to_dev(link.db_to_dev),
    .db_to_host(link.db_to_host), .rd_valid(link.rd_valid));

  always #4 clk = ~clk;

  // ==========================================================
  // watchdog and wire capture
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total++;
      summarize();
    end
  end

  always @(posedge clk) begin
    if (cap_on && link.strobe === 1'b1 &&
        link.read_not_write === 1'b0) begin
      capq.push_back(link.db_to_dev);
    end
  end

  // ==========================================================
  // tasks
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // one host request; read data lands in got
  task automatic req(input logic d, input logic r, input logic [7:0] b);
    int n;
    n = 0;
    got = 8'hXX;
    // status is only meaningful once execution has drained
    while (r && !d && busy_flag !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_is_data = d;
    req_is_read = r;
    req_byte = b;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (req_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      if (resp_valid === 1'b1) begin
        got = resp_byte;
      end
      n++;
    end
    if (n >= 2000) begin
      err_total++;
      $display("[ERR] %0t host request never completed", $time);
    end
  endtask : req

  task automatic cmd(input logic [7:0] b);
    req(1'b0, 1'b0, b);
  endtask : cmd

  task automatic wr(input logic [7:0] b);
    req(1'b1, 1'b0, b);
  endtask : wr

  task automatic peek(input lcd_pkg::mem_sel_t s, input logic [9:0] a,
                      input logic [15:0] e);
    @(negedge clk);
    scan_sel = s;
    scan_addr = a;
    @(negedge clk);
    chk(scan_word, e);
  endtask : peek

  // ==========================================================
  // sequence
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    chk(16'(flags), 16'h0080);
    cmd(8'h8A);
    chk(16'(address_counter), 16'h000A);
    chk(16'(busy_flag), 16'h0001);
    req(1'b0, 1'b1, 8'h00);
    chk(16'(got), 16'h000A);
    chk(16'(busy_flag), 16'h0000);
    wr(8'hAB);
    chk(16'(address_counter), 16'h000A);
    wr(8'hCD);
    chk(16'(address_counter), 16'h000B);
    peek(lcd_pkg::MEM_TEXT, 10'h012, 16'hABCD);
    cmd(8'h8A);
    req(1'b1, 1'b1, 8'h00);
    chk(16'(got), 16'h00AB);
    req(1'b1, 1'b1, 8'h00);
    chk(16'(got), 16'h00CD);
    chk(16'(address_counter), 16'h000B);
    cmd(8'h04);
    cmd(8'h85);
    wr(8'h11);
    wr(8'h22);
    chk(16'(address_counter), 16'h0004);
    cmd(8'h06);
    cmd(8'h7F);
    chk(16'(address_counter), 16'h003F);
    wr(8'h12);
    wr(8'h34);
    peek(lcd_pkg::MEM_GLYPH, 10'h03F, 16'h1234);
    cmd(8'h34);
    chk(16'(flags), 16'h00C0);
    cmd(8'h36);
    chk(16'(flags), 16'h04C0);
    cmd(8'h03);
    chk(16'(scroll_select), 16'h0001);
    cmd(8'h6A);
    chk(16'(scroll_offset), 16'h002A);
    cmd(8'h02);
    chk(16'(scroll_select), 16'h0000);
    m = 4'h0;
    for (int i = 0; i < 4; i++) begin
      cmd(8'h04 | 8'(i));
      m[i] = 1'b1;
      chk(16'(rowv), 16'({2'(i), m}));
    end
    cmd(8'h05);
    chk(16'(rowv), 16'h001D);
    cmd(8'h01);
    chk(16'(standby), 16'h0001);
    cmd(8'h02);
    chk(16'(standby), 16'h0000);
    peek(lcd_pkg::MEM_TEXT, 10'h012, 16'hABCD);
    cmd(8'h85);
    cmd(8'h8F);
    wr(8'h56);
    wr(8'h78);
    wr(8'h9A);
    wr(8'hBC);
    peek(lcd_pkg::MEM_BITMAP, 10'h05F, 16'h5678);
    peek(lcd_pkg::MEM_BITMAP, 10'h050, 16'h9ABC);
    cmd(8'h30);
    chk(16'(extended_set_select), 16'h0000);
    cmd(8'h20);
    chk(16'(bus_width_select), 16'h0000);
    cap_on = 1'b1;
    cmd(8'h8C);
    cap_on = 1'b0;
    chk(16'(address_counter), 16'h000C);
    chk(16'(capq[0]), 16'h0080);
    chk(16'(capq[1]), 16'h00C0);
    req(1'b0, 1'b1, 8'h00);
    chk(16'(got), 16'h000C);
    cmd(8'h24);
    cmd(8'h30);
    chk(16'({bus_width_select, extended_set_select}), 16'h0002);
    summarize();
  end
endmodule : test_lcd_extended_instruction_decoder
